// [hw/adc_readout_map.svh]
// Register offsets, field positions and timing figures of the readout block.
// Assumes a 100 MHz APB clock and 12-bit byte addresses.
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

`define CTRL_OFS 12'h000
`define TEST_CODE_OFS 12'h004
`define STATUS_OFS 12'h008
`define RESULT_OFS 12'h00c

`define CTRL_TEST_BIT 0
`define CTRL_RESET 1'h0
`define TEST_CODE_RESET 16'h0000
`define RESULT_RESET 16'h0000

`define ST_BUSY_BIT 0
`define ST_CONV_SLEEP_BIT 1
`define ST_OUT_SLEEP_BIT 2
`define ST_SETTLING_BIT 3
`define ST_VALID_BIT 4
`define ST_OUT_VALID_BIT 5

`define LOW_BYTE_FILL 8'hff

`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 180
// Pin fall to busy rise: three stages, filter register, state register
`define SYNC_LATENCY 5
`define SLEEP_ENTRY_NS 1500
`define CORE_WAKE_NS 5000
`define OUT_WAKE_NS 25000000

`endif

// [hw/adc_readout_pkg.sv]
// Types shared by the converter readout block.
// Assumes nothing beyond SystemVerilog packed types.
package adc_readout_pkg;

  typedef struct packed {
    logic conversion_start_n;
    logic reset_sleep_n;
    logic outputs_sleep_n;
    logic cs_n;
    logic rd_n;
    logic byte_sel;
  } host_pins_t;

  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

endpackage : adc_readout_pkg

// [hw/adc_readout.sv]
// Digital interface of a 16-bit sampling converter: result bus, busy,
// reset and the two sleep inputs, plus an APB status and test port.
// Assumes host pins are asynchronous to pclk and the SAR core presents
// its two's complement code on core_code.
// Function
// RULE1 - Drive result bus only when selected and read
// RULE2 - Host avoids reads around conversion start fall
// RULE3 - Result is two's complement, passed unchanged
// RULE4 - Byte select low: full word, MSB top
// RULE5 - Byte select high: low byte up, ones below
// RULE6 - Byte host reads upper then lower byte
// RULE7 - Byte reads work with toggled or held strobe
// RULE8 - Reset acts asynchronously; short pulse only resets
// RULE9 - Reset aborts conversion within 20 ns
// RULE10 - Short reset release resumes within 20 ns
// RULE11 - Low over 1.5 us sleeps converter core
// RULE12 - Release wakes core; valid after 5 us
// RULE13 - Both low sleeps all; outputs valid 25 ms
// RULE14 - Host never uses the reserved sleep combination
// RULE15 - Host may collect on busy falling
// RULE16 - Start low starts conversion, busy marks it
// RULE17 - Host holds start high 100 ns minimum
// RULE18 - Conversion completes within 180 ns
// RULE19 - Bus shows latest result, updated at busy fall
// RULE20 - Host avoids 0.5 to 1.5 us reset pulses
//
// Our own choices: the register offsets and the APB slave port.
`include "adc_readout_map.svh"

module adc_readout #(
  parameter int unsigned OUT_WAKE_CYCLES = `OUT_WAKE_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host pins
  input wire adc_readout_pkg::host_pins_t host,
  output logic busy,
  output logic [15:0] result_bus,
  output logic result_bus_oe,
  // Converter core
  input wire logic [15:0] core_code,
  output logic core_powered,
  output logic analog_outputs_powered,
  output logic analog_outputs_valid
);

  localparam int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS;
  localparam int RUN_CYCLES = CONV_CYCLES - `SYNC_LATENCY;
  localparam int SLEEP_CYCLES =
    (`SLEEP_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WAKE_CYCLES =
    (`CORE_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [4:0] RUN_LAST = 5'(RUN_CYCLES - 1);
  localparam logic [7:0] SLEEP_LAST = 8'(SLEEP_CYCLES - 1);
  localparam logic [9:0] WAKE_LOAD = 10'(WAKE_CYCLES);
  localparam logic [24:0] OUT_WAKE_LOAD = 25'(OUT_WAKE_CYCLES);

  // Pin synchronisers: three stages, a change counts when 2 and 3 agree
  adc_readout_pkg::host_pins_t sync1;
  adc_readout_pkg::host_pins_t sync2;
  adc_readout_pkg::host_pins_t sync3;
  adc_readout_pkg::host_pins_t pins;
  adc_readout_pkg::host_pins_t next_pins;
  localparam adc_readout_pkg::host_pins_t PINS_IDLE = '1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= PINS_IDLE;
      sync2 <= PINS_IDLE;
      sync3 <= PINS_IDLE;
      pins <= PINS_IDLE;
    end else begin
      sync1 <= host;
      sync2 <= sync1;
      sync3 <= sync2;
      pins <= next_pins;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < $bits(pins); gi++) begin : g_filter
      assign next_pins[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pins[gi];
    end
  endgenerate

  // Reset pin clears the conversion engine directly
  wire core_rst_n = presetn & host.reset_sleep_n; // see RULE8

  // Software registers
  logic test_enable;
  logic [15:0] test_code;
  logic [15:0] result;
  logic result_valid;

  // Conversion engine
  adc_readout_pkg::conv_state_t state;
  adc_readout_pkg::conv_state_t next_state;
  logic [4:0] run_cnt;
  logic [15:0] held_code;
  logic held_valid;
  logic start_prev;

  // Sleep control
  logic converter_asleep;
  logic [7:0] low_cnt;
  logic [7:0] both_cnt;
  logic [9:0] wake_cnt;
  logic [24:0] out_wake_cnt;

  wire start_fall = start_prev & ~pins.conversion_start_n;
  wire run_done = (state == adc_readout_pkg::CONV_RUN) &&
    (run_cnt == RUN_LAST);
  wire start_ok = start_fall & ~converter_asleep;
  wire [15:0] sample_code = test_enable ? test_code : core_code;

  always_comb begin
    next_state = state;
    case (state)
      adc_readout_pkg::CONV_IDLE: begin
        if (start_ok) begin
          next_state = adc_readout_pkg::CONV_RUN; // see RULE16
        end
      end
      adc_readout_pkg::CONV_RUN: begin
        if (run_done) begin
          next_state = adc_readout_pkg::CONV_IDLE; // see RULE18
        end
      end
      default: next_state = adc_readout_pkg::CONV_IDLE;
    endcase
  end

  // Aborted at once by the reset pin
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state <= adc_readout_pkg::CONV_IDLE; // see RULE9
      run_cnt <= '0;
      held_code <= `RESULT_RESET;
      held_valid <= 1'b0;
      start_prev <= 1'b1;
    end else begin
      state <= next_state; // see RULE10
      start_prev <= pins.conversion_start_n;
      run_cnt <= (state == adc_readout_pkg::CONV_RUN) ? run_cnt + 5'h01 : '0;
      if (state == adc_readout_pkg::CONV_IDLE && start_ok) begin
        held_code <= sample_code; // see RULE3
        held_valid <= (wake_cnt == '0); // see RULE12
      end
    end
  end

  assign busy = (state == adc_readout_pkg::CONV_RUN); // see RULE16

  // Result kept across resets of the engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= `RESULT_RESET;
      result_valid <= 1'b0;
    end else if (run_done && core_rst_n) begin
      result <= held_code; // see RULE19
      result_valid <= held_valid;
    end
  end

  // Byte folding onto the upper pins, fresh result at busy fall
  wire [15:0] next_result = (run_done && core_rst_n) ? held_code : result;
  wire [15:0] next_result_bus = pins.byte_sel ?
    {next_result[7:0], `LOW_BYTE_FILL} : next_result; // see RULE5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_bus <= `RESULT_RESET;
    end else begin
      result_bus <= next_result_bus; // see RULE4 RULE7
    end
  end

  assign result_bus_oe = ~pins.cs_n & ~pins.rd_n; // see RULE1

  // Sleep entry after a long low, wake timers after release
  wire rs_low = ~pins.reset_sleep_n;
  wire both_low = rs_low & ~pins.outputs_sleep_n;
  wire both_high = pins.reset_sleep_n & pins.outputs_sleep_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
      both_cnt <= '0;
      converter_asleep <= 1'b0;
      analog_outputs_powered <= 1'b1;
      wake_cnt <= '0;
      out_wake_cnt <= '0;
    end else begin
      low_cnt <= (rs_low && low_cnt != SLEEP_LAST) ? low_cnt + 8'h01 :
        (rs_low ? low_cnt : '0);
      both_cnt <= (both_low && both_cnt != SLEEP_LAST) ? both_cnt + 8'h01 :
        (both_low ? both_cnt : '0);
      if (rs_low && low_cnt == SLEEP_LAST) begin
        converter_asleep <= 1'b1; // see RULE11
      end else if (!rs_low) begin
        converter_asleep <= 1'b0;
      end
      if (converter_asleep && !rs_low) begin
        wake_cnt <= WAKE_LOAD; // see RULE12
      end else if (wake_cnt != '0) begin
        wake_cnt <= wake_cnt - 10'h001;
      end
      if (both_low && both_cnt == SLEEP_LAST) begin
        analog_outputs_powered <= 1'b0; // see RULE13
        out_wake_cnt <= '0;
      end else if (!analog_outputs_powered && both_high) begin
        analog_outputs_powered <= 1'b1;
        out_wake_cnt <= OUT_WAKE_LOAD;
      end else if (out_wake_cnt != '0) begin
        out_wake_cnt <= out_wake_cnt - 25'h0000001;
      end
    end
  end

  assign core_powered = ~converter_asleep;
  assign analog_outputs_valid = analog_outputs_powered &&
    (out_wake_cnt == '0);

  // APB slave: read data caught in the setup cycle, no wait states
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl = (paddr == `CTRL_OFS);
  wire hit_test = (paddr == `TEST_CODE_OFS);
  wire hit_status = (paddr == `STATUS_OFS);
  wire hit_result = (paddr == `RESULT_OFS);
  wire hit = hit_ctrl | hit_test | hit_status | hit_result;

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[`ST_BUSY_BIT] = busy;
    status_word[`ST_CONV_SLEEP_BIT] = converter_asleep;
    status_word[`ST_OUT_SLEEP_BIT] = ~analog_outputs_powered;
    status_word[`ST_SETTLING_BIT] = (wake_cnt != '0);
    status_word[`ST_VALID_BIT] = result_valid;
    status_word[`ST_OUT_VALID_BIT] = analog_outputs_valid;
  end

  wire [31:0] read_word =
    hit_ctrl ? {31'h0, test_enable} :
    hit_test ? {16'h0, test_code} :
    hit_status ? status_word :
    hit_result ? {16'h0, result} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      test_enable <= `CTRL_RESET;
      test_code <= `TEST_CODE_RESET;
    end else begin
      if (setup && !pwrite) begin
        prdata <= read_word;
      end
      if (access && pwrite && hit_ctrl) begin
        test_enable <= pwdata[`CTRL_TEST_BIT];
      end
      if (access && pwrite && hit_test) begin
        test_code <= pwdata[15:0];
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // Checks
  AST_BUS_DRIVE: assert property ( // see RULE1
    @(posedge pclk) disable iff (!presetn)
    (pins.cs_n || pins.rd_n) |-> !result_bus_oe)
    else $error("Result bus driven while not read");

  AST_WORD_MODE: assert property ( // see RULE4
    @(posedge pclk) disable iff (!presetn)
    !pins.byte_sel |=> result_bus == result)
    else $error("Word mode shows wrong value");

  AST_BYTE_MODE: assert property ( // see RULE5
    @(posedge pclk) disable iff (!presetn)
    pins.byte_sel |=> result_bus == {result[7:0], `LOW_BYTE_FILL})
    else $error("Byte mode shows wrong value");

  AST_ABORT: assert property ( // see RULE9
    @(posedge pclk) disable iff (!presetn)
    !host.reset_sleep_n |-> !busy)
    else $error("Conversion survived reset");

  AST_CONV_TIME: assert property ( // see RULE18
    @(posedge pclk) disable iff (!core_rst_n)
    $rose(busy) |-> ##[1:RUN_CYCLES] !busy)
    else $error("Conversion too long");

  AST_CODE_HELD: assert property ( // see RULE3
    @(posedge pclk) disable iff (!core_rst_n)
    (state == adc_readout_pkg::CONV_IDLE && start_ok) |=>
    held_code == $past(sample_code))
    else $error("Sampled code altered");

  AST_RESULT_LOAD: assert property ( // see RULE19
    @(posedge pclk) disable iff (!core_rst_n)
    run_done |=> (result == $past(held_code)) && !busy)
    else $error("Result not loaded at busy fall");

  AST_START_BUSY: assert property ( // see RULE16
    @(posedge pclk) disable iff (!core_rst_n)
    (start_fall && !converter_asleep && !busy) |=> busy)
    else $error("Start did not raise busy");

  AST_SHORT_RESET: assert property ( // see RULE8
    @(posedge pclk) disable iff (!presetn)
    $rose(converter_asleep) |-> $past(low_cnt) == SLEEP_LAST)
    else $error("Sleep entered before long low");

  AST_SLEEP_ENTRY: assert property ( // see RULE11
    @(posedge pclk) disable iff (!presetn)
    (rs_low && low_cnt == SLEEP_LAST) |=> converter_asleep)
    else $error("Core not asleep after long low");

  AST_WAKE_SETTLE: assert property ( // see RULE12
    @(posedge pclk) disable iff (!presetn)
    $fell(converter_asleep) |=> wake_cnt == WAKE_LOAD - 10'h001)
    else $error("Settle time not started on wake");

  AST_OUT_SLEEP: assert property ( // see RULE13
    @(posedge pclk) disable iff (!presetn)
    $fell(analog_outputs_powered) |-> $past(both_low) &&
    converter_asleep)
    else $error("Outputs slept without both low");

  AST_OUT_WAKE: assert property ( // see RULE13
    @(posedge pclk) disable iff (!presetn)
    $rose(analog_outputs_powered) |->
    !analog_outputs_valid && out_wake_cnt == OUT_WAKE_LOAD)
    else $error("Output settle time not started");

  COV_CONVERSION: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) ##[1:20] result_bus_oe);
  COV_BYTE_READ: cover property (@(posedge pclk) disable iff (!presetn)
    result_bus_oe && !pins.byte_sel ##[1:10] result_bus_oe && pins.byte_sel);
  COV_CORE_SLEEP: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(converter_asleep));
  COV_FULL_SLEEP: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(analog_outputs_valid));

endmodule : adc_readout

// [testbench/host_model.sv]
// Host side model: drives the converter pins and the core code.
// Assumes calls come right after a rising edge of pclk.
module host_model (
  // Clock
  input wire logic pclk,
  // Device outputs
  input wire logic busy,
  input wire logic [15:0] result_bus,
  input wire logic result_bus_oe,
  // Pins and core code
  output adc_readout_pkg::host_pins_t host,
  output logic [15:0] core_code
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host = '1;
    core_code = 16'h0000;
  end

  // Start low until busy is seen, then high again
  task automatic kick(output bit ok);
    int i;
    ok = 0;
    host.conversion_start_n <= 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge pclk);
      ok = (busy === 1'b1);
    end
    host.conversion_start_n <= 1'b1;
  endtask : kick

  // Gap before start, then busy length in cycles
  task automatic convert(output int n);
    bit ok;
    repeat (10) @(posedge pclk);
    kick(ok);
    n = 0;
    while (ok && busy === 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
  endtask : convert

  // Released bus reads back inverted, never as a stale match
  task automatic read(input logic sel, input bit hold,
                      output logic [15:0] v);
    host.cs_n <= 1'b0;
    host.rd_n <= 1'b0;
    host.byte_sel <= sel;
    repeat (7) @(posedge pclk);
    v = (result_bus_oe === 1'b1) ? result_bus : ~result_bus;
    if (!hold) begin
      host.cs_n <= 1'b1;
      host.rd_n <= 1'b1;
      // High long enough to pass the pin filter
      repeat (3) @(posedge pclk);
    end
  endtask : read

  // Reset pin never high while outputs pin is low
  task automatic pins(input logic rs, input logic os);
    @(posedge pclk);
    host.reset_sleep_n <= rs & os;
    host.outputs_sleep_n <= os;
  endtask : pins
endmodule : host_model

// [testbench/tb_adc_parallel_readout_powerdown.sv]
// Bench of the converter readout block: APB tasks, host model, checks.
// Assumes the package, map header and host model are compiled first.
`include "adc_readout_map.svh"
module tb_adc_parallel_readout_powerdown;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, r;
  logic pready, pslverr, busy, oe, err, core_pw, out_pw, out_ok;
  logic [15:0] result_bus, core_code, v;
  adc_readout_pkg::host_pins_t host;
  int n_mismatch = 0;
  int n_compared = 0;
  int n;
  bit ok;
  localparam int RUN_CYCLES =
    `CONV_TIME_NS / `CLK_PERIOD_NS - `SYNC_LATENCY;
  logic [15:0] codes [4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};

  always #5 pclk = ~pclk;

  adc_readout #(.OUT_WAKE_CYCLES(50)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host(host), .busy(busy),
    .result_bus(result_bus), .result_bus_oe(oe), .core_code(core_code),
    .core_powered(core_pw), .analog_outputs_powered(out_pw),
    .analog_outputs_valid(out_ok)
  );

  host_model hm (
    .pclk(pclk), .busy(busy), .result_bus(result_bus),
    .result_bus_oe(oe), .host(host), .core_code(core_code)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) n_mismatch++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                       input logic [31:0] mask);
    apb(1'b0, a, 32'h00000000, r);
    chk(r & mask, exp);
    chk({31'h0, err}, 32'h00000000);
  endtask : rdchk

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge pclk);
    chk({31'h0, oe}, 32'h00000000);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(`CTRL_OFS, 32'h00000000, 32'hffffffff);
    rdchk(`TEST_CODE_OFS, 32'h00000000, 32'hffffffff);
    rdchk(`STATUS_OFS, 32'h00000020, 32'h00000027);
    apb(1'b0, 12'h010, 32'h00000000, r);
    chk(r, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b1, `CTRL_OFS, 32'h00000001, r);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `TEST_CODE_OFS, {16'h0000, codes[k]}, r);
      hm.convert(n);
      chk(32'(n), 32'(RUN_CYCLES));
      hm.read(1'b0, k[0], v);
      chk({16'h0000, v}, {16'h0000, codes[k]});
      hm.read(1'b1, 1'b0, v);
      chk({16'h0000, v}, {16'h0000, codes[k][7:0], 8'hff});
      repeat (6) @(posedge pclk);
      chk({31'h0, oe}, 32'h00000000);
      rdchk(`RESULT_OFS, {16'h0000, codes[k]}, 32'hffffffff);
    end
    apb(1'b1, `CTRL_OFS, 32'h00000000, r);
    hm.core_code <= 16'h8001;
    hm.convert(n);
    hm.read(1'b0, 1'b0, v);
    chk({16'h0000, v}, 32'h00008001);
    hm.kick(ok);
    hm.pins(1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    chk({30'h0, ok, busy}, 32'h00000002);
    hm.pins(1'b1, 1'b1);
    chk({31'h0, core_pw}, 32'h00000001);
    rdchk(`RESULT_OFS, 32'h00008001, 32'hffffffff);
    hm.convert(n);
    chk(32'(n), 32'(RUN_CYCLES));
    hm.pins(1'b0, 1'b1);
    repeat (160) @(posedge pclk);
    chk({30'h0, core_pw, out_pw}, 32'h00000001);
    rdchk(`STATUS_OFS, 32'h00000002, 32'h00000007);
    hm.pins(1'b1, 1'b1);
    repeat (6) @(posedge pclk);
    chk({31'h0, core_pw}, 32'h00000001);
    rdchk(`STATUS_OFS, 32'h00000008, 32'h0000000f);
    hm.convert(n);
    rdchk(`STATUS_OFS, 32'h00000008, 32'h00000018);
    hm.pins(1'b0, 1'b0);
    repeat (160) @(posedge pclk);
    chk({30'h0, out_pw, out_ok}, 32'h00000000);
    hm.pins(1'b1, 1'b1);
    repeat (10) @(posedge pclk);
    chk({30'h0, out_pw, out_ok}, 32'h00000002);
    repeat (60) @(posedge pclk);
    chk({30'h0, out_pw, out_ok}, 32'h00000003);
    end_sim();
  end
endmodule : tb_adc_parallel_readout_powerdown
